// File: dbsp_sram_port.sv
// How it works
// - Load low and select low on clock rise starts write; words follow next cycle
// - Load low, select high starts read; words on the fall after the next rise, then the rise after
// - Second burst address flips only the address LSB, no carry
// - Narrow width: both selects low writes both lanes of the word
// - Narrow width: only select zero low writes bits 8 to 0
// - Narrow width: only select one low writes bits 17 to 9
// - Narrow width: both selects high writes nothing from that word
// - Wide width: all four selects low writes the full word
// - Wide width: each select gates its own nine-bit lane
// - Wide width: all selects high writes nothing from that word
// - Lane selects are sampled afresh with each data word
// - After power-up the device is deselected, bus floating
// - Write data is captured on both input clock edges
// - Read data launches from output clock edges, here the input pair
// - Read right after a write returns the newest, still pending data
// - Loop bypassed gives one cycle read latency instead of one and a half
module dbsp_sram_port #(
    parameter int WIDTH = dbsp_pkg::DEF_WIDTH,
    parameter int ADDR_W = dbsp_pkg::DEF_ADDR_W,
    parameter int CNT_W = dbsp_pkg::DEF_CNT_W
) (
    input wire logic core_clk,                                  // Core clock
    input wire logic arst_n,                                    // Async reset, active low
    input wire logic link_clk,                                  // Input clock pair, true phase
    input wire logic load_strobe_n,                             // Cycle start, active low
    input wire logic rw_sel,                                    // High read, low write
    input wire logic [ADDR_W-1:0] addr_in,                      // Burst address
    input wire logic [WIDTH/dbsp_pkg::LANE_W-1:0] lane_write_select_n, // Lane selects
    input wire logic [WIDTH-1:0] dq_in,                         // Data bus, input side
    output logic [WIDTH-1:0] dq_out,                            // Data bus, output side
    output logic dq_oe,                                         // Data bus drive enable
    output logic echo_timing_out,                               // Echo of read clock
    input wire logic loop_bypass_n,                             // Low bypasses the loop
    output logic [CNT_W-1:0] rd_count,                          // Reads started
    output logic [CNT_W-1:0] wr_count                           // Writes started
);
    localparam int LW = dbsp_pkg::LANE_W;
    localparam int LANES = WIDTH / LW;
    localparam int DEPTH = 2 ** ADDR_W;
    localparam logic [ADDR_W-1:0] BURST_MASK = {{(ADDR_W-1){1'b0}}, dbsp_pkg::BURST_FLIP};

    // Link reset: asserted at once, released on a link edge
    logic link_rst_meta_reg;
    logic link_rst_n_reg;

    always_ff @(posedge link_clk or negedge arst_n) begin
        if (!arst_n) begin
            link_rst_meta_reg <= 1'b0;
            link_rst_n_reg <= 1'b0;
        end else begin
            link_rst_meta_reg <= 1'b1;
            link_rst_n_reg <= link_rst_meta_reg;
        end
    end

    // Loop strap, caught once after reset release
    logic bypass_meta_reg;
    logic bypass_sync_reg;
    logic [1:0] strap_age_reg;
    logic [1:0] strap_age_next;
    logic strap_done_reg;
    logic strap_done_next;
    logic dll_on_reg;
    logic dll_on_next;

    always_comb begin
        strap_age_next = (strap_age_reg == dbsp_pkg::STRAP_AGE) ? strap_age_reg
                                                                 : strap_age_reg + 2'h1;
        strap_done_next = strap_done_reg | (strap_age_reg == dbsp_pkg::STRAP_AGE);
        dll_on_next = dll_on_reg;
        if (!strap_done_reg && strap_age_reg == dbsp_pkg::STRAP_AGE) begin
            dll_on_next = bypass_sync_reg;
        end
    end

    always_ff @(posedge link_clk or negedge link_rst_n_reg) begin
        if (!link_rst_n_reg) begin
            bypass_meta_reg <= 1'b1;
            bypass_sync_reg <= 1'b1;
            strap_age_reg <= 2'h0;
            strap_done_reg <= 1'b0;
            dll_on_reg <= 1'b1;
        end else begin
            bypass_meta_reg <= loop_bypass_n;
            bypass_sync_reg <= bypass_meta_reg;
            strap_age_reg <= strap_age_next;
            strap_done_reg <= strap_done_next;
            dll_on_reg <= dll_on_next;
        end
    end

    // Command decode on the true input clock rise
    dbsp_pkg::dbsp_cmd_t cmd_now;
    dbsp_pkg::dbsp_cmd_t cmd_s1_reg;
    dbsp_pkg::dbsp_cmd_t cmd_s2_reg;
    logic [ADDR_W-1:0] addr_s1_reg;
    logic [ADDR_W-1:0] addr_s1_next;
    logic [ADDR_W-1:0] addr_s2_reg;
    logic [1:0] tgl_reg;
    logic [1:0] tgl_next;

    always_comb begin
        if (load_strobe_n) begin
            cmd_now = dbsp_pkg::DBSP_IDLE;
        end else if (rw_sel) begin
            cmd_now = dbsp_pkg::DBSP_READ;
        end else begin
            cmd_now = dbsp_pkg::DBSP_WRITE;
        end
        addr_s1_next = load_strobe_n ? addr_s1_reg : addr_in;
        tgl_next = tgl_reg;
        tgl_next[dbsp_pkg::EVT_RD] = tgl_reg[dbsp_pkg::EVT_RD] ^ (cmd_now == dbsp_pkg::DBSP_READ);
        tgl_next[dbsp_pkg::EVT_WR] = tgl_reg[dbsp_pkg::EVT_WR] ^ (cmd_now == dbsp_pkg::DBSP_WRITE);
    end

    always_ff @(posedge link_clk or negedge link_rst_n_reg) begin
        if (!link_rst_n_reg) begin
            cmd_s1_reg <= dbsp_pkg::DBSP_IDLE;
            cmd_s2_reg <= dbsp_pkg::DBSP_IDLE;
            addr_s1_reg <= '0;
            addr_s2_reg <= '0;
            tgl_reg <= 2'h0;
        end else begin
            cmd_s1_reg <= cmd_now;
            cmd_s2_reg <= cmd_s1_reg;
            addr_s1_reg <= addr_s1_next;
            addr_s2_reg <= addr_s1_reg;
            tgl_reg <= tgl_next;
        end
    end

    // Live lane mask from the selects, one field per lane
    logic [WIDTH-1:0] live_mask;

    for (genvar g = 0; g < LANES; g++) begin : g_lane
        assign live_mask[g*LW +: LW] = {LW{~lane_write_select_n[g]}};
    end

    // Storage and its two write ports
    logic [WIDTH-1:0] mem [DEPTH];
    logic wa_en;
    logic [ADDR_W-1:0] wa_addr;
    logic [WIDTH-1:0] wa_data;
    logic [WIDTH-1:0] wa_mask;
    logic wb_en;
    logic [ADDR_W-1:0] wb_addr;
    logic [WIDTH-1:0] wb_data;
    logic [WIDTH-1:0] wb_mask;
    logic [WIDTH-1:0] w2_data_reg;
    logic [WIDTH-1:0] w2_data_next;
    logic [WIDTH-1:0] w2_mask_reg;
    logic [WIDTH-1:0] w2_mask_next;

    always_comb begin
        // Port A: second word of the older write
        wa_en = (cmd_s2_reg == dbsp_pkg::DBSP_WRITE);
        wa_addr = addr_s2_reg ^ BURST_MASK;
        wa_data = w2_data_reg;
        wa_mask = w2_mask_reg;
        // Port B: first word of the newer write, straight off the pins
        wb_en = (cmd_s1_reg == dbsp_pkg::DBSP_WRITE);
        wb_addr = addr_s1_reg;
        wb_data = dq_in;
        wb_mask = live_mask;
        // Back-to-back writes may hit one word; fold both so no lane is lost
        if (wa_en && wb_en && wa_addr == wb_addr) begin
            wa_en = 1'b0;
            wb_data = (w2_data_reg & w2_mask_reg & ~live_mask) | (dq_in & live_mask);
            wb_mask = w2_mask_reg | live_mask;
        end
    end

    always_ff @(posedge link_clk) begin
        if (wa_en) begin
            mem[wa_addr] <= (mem[wa_addr] & ~wa_mask) | (wa_data & wa_mask);
        end
        if (wb_en) begin
            mem[wb_addr] <= (mem[wb_addr] & ~wb_mask) | (wb_data & wb_mask);
        end
    end

    // Output pair: each half holds pos ^ neg so the pin sees one flop per edge
    logic [WIDTH-1:0] dq_pos_reg;
    logic [WIDTH-1:0] dq_pos_next;
    logic [WIDTH-1:0] dq_neg_reg;
    logic [WIDTH-1:0] dq_neg_next;
    logic oe_pos_reg;
    logic oe_pos_next;
    logic oe_neg_reg;
    logic oe_neg_next;
    logic echo_pos_reg;
    logic echo_pos_next;
    logic echo_neg_reg;
    logic echo_neg_next;
    logic pos_drive;
    logic [ADDR_W-1:0] pos_rd_addr;
    logic [WIDTH-1:0] pos_rd_word;
    logic neg_drive;
    logic [ADDR_W-1:0] neg_rd_addr;

    always_comb begin
        // Rise: second word with the loop on, first word with it bypassed
        pos_drive = dll_on_reg ? (cmd_s2_reg == dbsp_pkg::DBSP_READ)
                               : (cmd_s1_reg == dbsp_pkg::DBSP_READ);
        pos_rd_addr = dll_on_reg ? (addr_s2_reg ^ BURST_MASK) : addr_s1_reg;
        pos_rd_word = mem[pos_rd_addr];
        if (wa_en && wa_addr == pos_rd_addr) begin
            pos_rd_word = (mem[pos_rd_addr] & ~wa_mask) | (wa_data & wa_mask);
        end
        dq_pos_next = (pos_drive ? pos_rd_word : dq_out) ^ dq_neg_reg;
        oe_pos_next = pos_drive ^ oe_neg_reg;
        echo_pos_next = ~echo_neg_reg;
    end

    always_ff @(posedge link_clk or negedge link_rst_n_reg) begin
        if (!link_rst_n_reg) begin
            dq_pos_reg <= '0;
            oe_pos_reg <= 1'b0;
            echo_pos_reg <= 1'b0;
        end else begin
            dq_pos_reg <= dq_pos_next;
            oe_pos_reg <= oe_pos_next;
            echo_pos_reg <= echo_pos_next;
        end
    end

    always_comb begin
        // Complementary rise: first word with the loop on, second with it bypassed
        neg_drive = (cmd_s2_reg == dbsp_pkg::DBSP_READ);
        neg_rd_addr = dll_on_reg ? addr_s2_reg : (addr_s2_reg ^ BURST_MASK);
        dq_neg_next = (neg_drive ? mem[neg_rd_addr] : dq_out) ^ dq_pos_reg;
        oe_neg_next = (neg_drive | dq_oe) ^ oe_pos_reg;
        echo_neg_next = echo_pos_reg;
        // Second write word with its own lane selects
        w2_data_next = (cmd_s2_reg == dbsp_pkg::DBSP_WRITE) ? dq_in : w2_data_reg;
        w2_mask_next = (cmd_s2_reg == dbsp_pkg::DBSP_WRITE) ? live_mask : w2_mask_reg;
    end

    always_ff @(negedge link_clk or negedge link_rst_n_reg) begin
        if (!link_rst_n_reg) begin
            dq_neg_reg <= '0;
            oe_neg_reg <= 1'b0;
            echo_neg_reg <= 1'b0;
            w2_data_reg <= '0;
            w2_mask_reg <= '0;
        end else begin
            dq_neg_reg <= dq_neg_next;
            oe_neg_reg <= oe_neg_next;
            echo_neg_reg <= echo_neg_next;
            w2_data_reg <= w2_data_next;
            w2_mask_reg <= w2_mask_next;
        end
    end

    // No edge, no change: a stopped clock freezes the pins
    assign dq_out = dq_pos_reg ^ dq_neg_reg;
    assign dq_oe = oe_pos_reg ^ oe_neg_reg;
    assign echo_timing_out = echo_pos_reg ^ echo_neg_reg;

    // Events into the core clock domain
    dbsp_evt_if #(.N(dbsp_pkg::EVT_N)) evt ();
    logic [dbsp_pkg::EVT_N-1:0] evt_pulse;
    logic [CNT_W-1:0] rd_count_reg;
    logic [CNT_W-1:0] rd_count_next;
    logic [CNT_W-1:0] wr_count_reg;
    logic [CNT_W-1:0] wr_count_next;

    assign evt.tgl = tgl_reg;

    dbsp_evt_sync #(.N(dbsp_pkg::EVT_N)) u_evt_sync (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .evt(evt),
        .evt_pulse(evt_pulse)
    );

    always_comb begin
        rd_count_next = evt_pulse[dbsp_pkg::EVT_RD] ? rd_count_reg + CNT_W'(1) : rd_count_reg;
        wr_count_next = evt_pulse[dbsp_pkg::EVT_WR] ? wr_count_reg + CNT_W'(1) : wr_count_reg;
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_count_reg <= '0;
            wr_count_reg <= '0;
        end else begin
            rd_count_reg <= rd_count_next;
            wr_count_reg <= wr_count_next;
        end
    end

    assign rd_count = rd_count_reg;
    assign wr_count = wr_count_reg;

    // Checking aids: capture port B writes to compare one rise later
    logic chk_valid_reg;
    logic [ADDR_W-1:0] chk_addr_reg;
    logic [WIDTH-1:0] chk_old_reg;
    logic [WIDTH-1:0] chk_data_reg;
    logic [WIDTH-1:0] chk_mask_reg;
    logic rd_cmd;
    logic wr_cmd;

    assign rd_cmd = (cmd_now == dbsp_pkg::DBSP_READ);
    assign wr_cmd = (cmd_now == dbsp_pkg::DBSP_WRITE);

    always_ff @(posedge link_clk or negedge link_rst_n_reg) begin
        if (!link_rst_n_reg) begin
            chk_valid_reg <= 1'b0;
            chk_addr_reg <= '0;
            chk_old_reg <= '0;
            chk_data_reg <= '0;
            chk_mask_reg <= '0;
        end else begin
            chk_valid_reg <= wb_en;
            chk_addr_reg <= wb_addr;
            chk_old_reg <= mem[wb_addr];
            chk_data_reg <= wb_data;
            chk_mask_reg <= wb_mask;
        end
    end

    property p_wr_first;
        @(posedge link_clk) disable iff (!link_rst_n_reg)
        wr_cmd |=> (wb_en && wb_addr == $past(addr_in));
    endproperty
    a_wr_first: assert property (p_wr_first) else $error("first write word not aimed at address");

    property p_wr_second;
        @(posedge link_clk) disable iff (!link_rst_n_reg)
        wr_cmd ##1 !wr_cmd |-> ##1 (wa_en && wa_addr == ($past(addr_in, 2) ^ BURST_MASK));
    endproperty
    a_wr_second: assert property (p_wr_second) else $error("second write word address wrong");

    property p_lane_written;
        @(posedge link_clk) disable iff (!link_rst_n_reg)
        chk_valid_reg |-> ((mem[chk_addr_reg] & chk_mask_reg) == (chk_data_reg & chk_mask_reg));
    endproperty
    a_lane_written: assert property (p_lane_written) else $error("selected lane not stored");

    property p_lane_kept;
        @(posedge link_clk) disable iff (!link_rst_n_reg)
        chk_valid_reg |-> ((mem[chk_addr_reg] & ~chk_mask_reg) == (chk_old_reg & ~chk_mask_reg));
    endproperty
    a_lane_kept: assert property (p_lane_kept) else $error("unselected lane altered");

    property p_rd_dll_on;
        @(posedge link_clk) disable iff (!link_rst_n_reg)
        (rd_cmd && dll_on_reg) ##1 !rd_cmd ##1 !rd_cmd |=> dq_oe;
    endproperty
    a_rd_dll_on: assert property (p_rd_dll_on) else $error("read burst ended early");

    property p_rd_dll_off;
        @(posedge link_clk) disable iff (!link_rst_n_reg)
        (rd_cmd && !dll_on_reg) ##1 !rd_cmd ##1 !rd_cmd |=> !dq_oe;
    endproperty
    a_rd_dll_off: assert property (p_rd_dll_off) else $error("bypass read latency wrong");

    property p_nop_hiz;
        @(posedge link_clk) disable iff (!link_rst_n_reg)
        !rd_cmd ##1 !rd_cmd ##1 !rd_cmd |=> !dq_oe;
    endproperty
    a_nop_hiz: assert property (p_nop_hiz) else $error("bus driven with no read pending");

    property p_reset_hiz;
        @(posedge link_clk) disable iff (!arst_n)
        $rose(link_rst_n_reg) |-> (!dq_oe && !oe_pos_reg);
    endproperty
    a_reset_hiz: assert property (p_reset_hiz) else $error("bus driven after reset");

    c_write: cover property (@(posedge link_clk) disable iff (!link_rst_n_reg)
        wr_cmd ##1 wb_en ##1 wa_en);
    c_read_on: cover property (@(posedge link_clk) disable iff (!link_rst_n_reg)
        rd_cmd && dll_on_reg ##2 dq_oe);
    c_read_off: cover property (@(posedge link_clk) disable iff (!link_rst_n_reg)
        rd_cmd && !dll_on_reg ##1 pos_drive);
    c_bypass: cover property (@(posedge link_clk) disable iff (!link_rst_n_reg)
        pos_drive && wa_en && wa_addr == pos_rd_addr);
endmodule

// File: dbsp_pkg.sv
package dbsp_pkg;
    // Lane geometry
    localparam int LANE_W = 9;
    localparam int DEF_WIDTH = 18;
    localparam int DEF_ADDR_W = 21;
    localparam int DEF_CNT_W = 16;

    // Burst partner address is the first address with this LSB flipped
    localparam logic BURST_FLIP = 1'b1;

    // Edges after link reset release before the strap is trusted
    localparam logic [1:0] STRAP_AGE = 2'h2;

    // Event channels crossing to the core clock
    localparam int EVT_N = 2;
    localparam int EVT_RD = 0;
    localparam int EVT_WR = 1;

    // Clocks: core 20 MHz, link clock period in the bench
    localparam int CORE_CLK_NS = 50;
    localparam int LINK_CLK_NS = 160;

    typedef enum logic [1:0] {
        DBSP_IDLE  = 2'b00,
        DBSP_READ  = 2'b01,
        DBSP_WRITE = 2'b10
    } dbsp_cmd_t;
endpackage

// File: dbsp_evt_if.sv
interface dbsp_evt_if #(
    parameter int N = dbsp_pkg::EVT_N
) ();
    logic [N-1:0] tgl;

    modport src (output tgl);
    modport dst (input tgl);
endinterface

// File: dbsp_evt_sync.sv
module dbsp_evt_sync #(
    parameter int N = dbsp_pkg::EVT_N
) (
    input wire logic core_clk,           // Core clock
    input wire logic arst_n,             // Asynchronous reset, active low
    dbsp_evt_if.dst evt,                 // Toggles from the link domain
    output logic [N-1:0] evt_pulse       // One core cycle per link event
);
    for (genvar g = 0; g < N; g++) begin : g_chan
        logic meta_reg;
        logic sync_reg;
        logic seen_reg;
        logic pulse_reg;
        logic seen_next;
        logic pulse_next;

        // Toggle crossing: one event per level change, never lost
        always_comb begin
            seen_next = sync_reg;
            pulse_next = sync_reg ^ seen_reg;
        end

        always_ff @(posedge core_clk or negedge arst_n) begin
            if (!arst_n) begin
                meta_reg <= 1'b0;
                sync_reg <= 1'b0;
                seen_reg <= 1'b0;
                pulse_reg <= 1'b0;
            end else begin
                meta_reg <= evt.tgl[g];
                sync_reg <= meta_reg;
                seen_reg <= seen_next;
                pulse_reg <= pulse_next;
            end
        end

        assign evt_pulse[g] = pulse_reg;
    end
endmodule

// File: dbsp_ctrl_model.sv
module dbsp_ctrl_model #(
    parameter int WIDTH = dbsp_pkg::DEF_WIDTH,
    parameter int ADDR_W = 4
) (
    input wire logic link_clk,                                    // Input clock, true phase
    input wire logic [WIDTH-1:0] dq_out,                          // Read data from the device
    input wire logic dq_oe,                                       // Device drives the bus
    output logic load_strobe_n,                                   // Cycle start, active low
    output logic rw_sel,                                          // High read, low write
    output logic [ADDR_W-1:0] addr_in,                            // Burst address
    output logic [WIDTH/dbsp_pkg::LANE_W-1:0] lane_write_select_n, // Lane selects
    output logic [WIDTH-1:0] dq_in                                // Write data
);
    // No output clock pins: single clock mode fixed from power-on
    timeunit 1ns;
    timeprecision 1ps;
    logic data_phase;

    initial begin
        load_strobe_n = 1'b1;
        rw_sel = 1'b0;
        addr_in = '0;
        lane_write_select_n = '1;
        dq_in = '0;
        data_phase = 1'b0;
    end

    // Released lines never hold a stale word, so a late capture shows up
    always @(posedge link_clk) begin
        if (!data_phase) begin
            dq_in <= ~dq_in;
            lane_write_select_n <= ~lane_write_select_n;
        end
    end

    task automatic write(input logic [ADDR_W-1:0] a, input logic [WIDTH-1:0] d1, d2,
                         input logic [WIDTH/dbsp_pkg::LANE_W-1:0] s1, s2,
                         input logic rd_next);
        @(posedge link_clk);
        data_phase = 1'b1;
        load_strobe_n <= 1'b0;
        rw_sel <= 1'b0;
        addr_in <= a;
        @(posedge link_clk);
        load_strobe_n <= !rd_next;
        rw_sel <= rd_next;
        dq_in <= d1;
        lane_write_select_n <= s1;
        // Second word must still stand at the fall after this rise
        @(posedge link_clk);
        load_strobe_n <= 1'b1;
        dq_in <= d2;
        lane_write_select_n <= s2;
        @(negedge link_clk);
        data_phase = 1'b0;
    endtask

    task automatic read(input logic [ADDR_W-1:0] a, input logic issued,
                        output logic [WIDTH-1:0] q0, q1, q2, output logic [3:0] oe);
        if (!issued) begin
            @(posedge link_clk);
            load_strobe_n <= 1'b0;
            rw_sel <= 1'b1;
            addr_in <= a;
            @(posedge link_clk);
            load_strobe_n <= 1'b1;
            addr_in <= ~a;
        end
        // Sample both edges of t + 1, then rises t + 2 and t + 3
        @(posedge link_clk);
        #20;
        q0 = dq_out;
        oe[3] = dq_oe;
        @(negedge link_clk);
        #20;
        q1 = dq_out;
        oe[2] = dq_oe;
        @(posedge link_clk);
        #20;
        q2 = dq_out;
        oe[1] = dq_oe;
        // This rise stays idle before any write follows
        @(posedge link_clk);
        #20;
        oe[0] = dq_oe;
    endtask
endmodule

// File: testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int AW = 4;
    localparam int W = 18;
    localparam int LN = W / dbsp_pkg::LANE_W;
    logic core_clk, arst_n, link_clk, link_run, load_strobe_n, rw_sel, dq_oe, echo_timing_out;
    logic loop_bypass_n = 1'b1;
    logic bypass_mode = 1'b0;
    logic [AW-1:0] addr_in;
    logic [LN-1:0] lane_write_select_n;
    logic [W-1:0] dq_in, dq_out;
    logic [dbsp_pkg::DEF_CNT_W-1:0] rd_count, wr_count;
    logic [W-1:0] ref_mem [2**AW];
    int miscompares = 0;
    int checked = 0;
    int n_rd = 0;
    int n_wr = 0;

    dbsp_sram_port #(.WIDTH(W), .ADDR_W(AW)) dut (.core_clk(core_clk), .arst_n(arst_n),
        .link_clk(link_clk), .load_strobe_n(load_strobe_n), .rw_sel(rw_sel),
        .addr_in(addr_in), .lane_write_select_n(lane_write_select_n), .dq_in(dq_in),
        .dq_out(dq_out), .dq_oe(dq_oe), .echo_timing_out(echo_timing_out),
        .loop_bypass_n(loop_bypass_n), .rd_count(rd_count), .wr_count(wr_count));

    dbsp_ctrl_model #(.WIDTH(W), .ADDR_W(AW)) ctrl (.link_clk(link_clk), .dq_out(dq_out),
        .dq_oe(dq_oe), .load_strobe_n(load_strobe_n), .rw_sel(rw_sel), .addr_in(addr_in),
        .lane_write_select_n(lane_write_select_n), .dq_in(dq_in));

    initial begin
        core_clk = 1'b0;
        forever #(dbsp_pkg::CORE_CLK_NS / 2) core_clk = ~core_clk;
    end

    // Odd start offset keeps the two clocks out of phase
    initial begin
        link_clk = 1'b0;
        link_run = 1'b1;
        #13;
        forever #(dbsp_pkg::LINK_CLK_NS / 2) link_clk = link_run ? ~link_clk : link_clk;
    end

    task automatic end_of_test();
        if (miscompares == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic check(input logic [W-1:0] got, exp, input string what);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask

    function automatic logic [W-1:0] merge(input logic [W-1:0] old, nw,
                                           input logic [LN-1:0] sel);
        logic [W-1:0] r;
        r = old;
        for (int i = 0; i < LN; i++) begin
            if (!sel[i]) begin
                r[i*dbsp_pkg::LANE_W +: dbsp_pkg::LANE_W] = nw[i*dbsp_pkg::LANE_W +: 9];
            end
        end
        return r;
    endfunction

    task automatic wr(input logic [AW-1:0] a, input logic [W-1:0] d1, d2,
                      input logic [LN-1:0] s1, s2, input logic rd_next);
        ref_mem[a] = merge(ref_mem[a], d1, s1);
        ref_mem[{a[AW-1:1], ~a[0]}] = merge(ref_mem[{a[AW-1:1], ~a[0]}], d2, s2);
        n_wr++;
        ctrl.write(a, d1, d2, s1, s2, rd_next);
    endtask

    task automatic rd(input logic [AW-1:0] a, input logic issued, input string what);
        logic [W-1:0] q0, q1, q2;
        logic [3:0] oe;
        n_rd++;
        ctrl.read(a, issued, q0, q1, q2, oe);
        if (bypass_mode) begin
            check(q0, ref_mem[a], what);
            check(q1, ref_mem[{a[AW-1:1], ~a[0]}], what);
            check(W'(oe), W'(4'hc), what);
        end else begin
            check(q1, ref_mem[a], what);
            check(q2, ref_mem[{a[AW-1:1], ~a[0]}], what);
            check(W'(oe), W'(4'h6), what);
        end
    endtask

    // Every select code on each edge, odd and even first addresses
    task automatic sc_lanes();
        logic [AW-1:0] a;
        for (int k = 0; k < 4; k++) begin
            a = AW'(2 * k + k % 2);
            wr(a, 18'h2aaaa, 18'h15555, 2'h0, 2'h0, 1'b0);
            rd(a, 1'b0, "full lanes");
            wr(a, 18'h3c3c3, 18'h0c30c, LN'(k), ~LN'(k), 1'b0);
            rd(a, 1'b0, "lane merge");
        end
    endtask

    task automatic sc_fwd();
        wr(4'h9, 18'h12345, 18'h2fedc, 2'h0, 2'h0, 1'b1);
        rd(4'h9, 1'b1, "read after write");
    endtask

    // Link clock parked low with the first read word on the bus
    task automatic sc_stop();
        logic [W-1:0] held;
        fork
            rd(4'h5, 1'b0, "stopped read");
            begin
                repeat (3) @(posedge link_clk);
                @(negedge link_clk);
                #30;
                held = dq_out;
                link_run = 1'b0;
                #1000;
                check(dq_out, held, "stopped data");
                check(W'(dq_oe), W'(1'b1), "stopped enable");
                link_run = 1'b1;
            end
        join
    endtask

    task automatic sc_counts();
        int n;
        n = 0;
        while ((rd_count !== 16'(n_rd) || wr_count !== 16'(n_wr)) && n < 40) begin
            @(posedge core_clk);
            n++;
        end
        check(W'(rd_count), W'(n_rd), "read count");
        check(W'(wr_count), W'(n_wr), "write count");
    endtask

    // Mid-run reset with the loop strapped off: one cycle read latency
    task automatic sc_bypass();
        @(posedge core_clk);
        arst_n <= 1'b0;
        loop_bypass_n <= 1'b0;
        repeat (8) @(posedge core_clk);
        arst_n <= 1'b1;
        n_rd = 0;
        n_wr = 0;
        bypass_mode = 1'b1;
        repeat (8) @(posedge link_clk);
        check(W'(dq_oe), W'(1'b0), "reset float");
        wr(4'h6, 18'h1b2c3, 18'h0d4e5, 2'h0, 2'h1, 1'b1);
        rd(4'h6, 1'b1, "bypass forward");
        rd(4'h7, 1'b0, "bypass read");
        sc_counts();
    endtask

    initial begin
        arst_n = 1'b0;
        repeat (8) @(posedge core_clk);
        arst_n <= 1'b1;
        repeat (8) @(posedge link_clk);
        check(W'(dq_oe), W'(1'b0), "power-up float");
        @(negedge link_clk);
        #20;
        check(W'(echo_timing_out), W'(1'b0), "echo low");
        @(posedge link_clk);
        #20;
        check(W'(echo_timing_out), W'(1'b1), "echo high");
        sc_lanes();
        sc_fwd();
        sc_stop();
        sc_counts();
        sc_bypass();
        end_of_test();
    end
endmodule
